// ---- include/t0cp_pkg.sv ----
// t0cp package: constants and carriers for the timer0 counter block
package t0cp_pkg;

    // phase clocks per instruction cycle
    localparam int unsigned CLKS_PER_INSN = 4;
    // instruction cycles of count suppression after a low-byte write
    localparam logic [1:0]  INHIBIT_INSN  = 2'h2;

    // values after reset
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [7:0]  BUFFER_RESET  = 8'h00;
    localparam logic [7:0]  PRESCALE_ZERO = 8'h00;

    // wrap points
    localparam logic [7:0]  LOW_TOP       = 8'hff;
    localparam logic [15:0] WORD_TOP      = 16'hffff;

    // configuration bits
    typedef struct packed {
        logic       width_select;        // 1 = 8-bit, 0 = 16-bit
        logic       count_source_select; // 1 = external pin
        logic       count_edge_select;   // 1 = falling edge
        logic       prescaler_assign;    // 0 = prescaler feeds timer
        logic [2:0] prescale_ratio_field;
    } t0cp_cfg_s;

    // software access strobes, one cycle each
    typedef struct packed {
        logic       wr_low;
        logic       wr_high;
        logic       rd_low;
        logic       flag_clear;
        logic [7:0] data;
    } t0cp_sw_s;

endpackage : t0cp_pkg

// ---- tb/t0cp_pin_model.sv ----
// t0cp_pin_model: external count source driving pulse trains on the pin
`timescale 1ns/1ps
`default_nettype none

module t0cp_pin_model (
    // clock
    input  wire logic       clk,
    // request from the bench
    input  wire logic       start,
    input  wire logic [7:0] n,
    input  wire logic       slow,
    // count pin
    output logic            pin
);
    int left = 0;
    int hold = 0;

    initial pin = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // each level lasts 3 or 6 clocks, never below the two the sync needs
    always @(posedge clk)
    begin
        if (start)
        begin
            left <= 2 * n;
            hold <= 0;
        end
        else if (left > 0 && hold == 0)
        begin
            pin  <= ~pin;
            left <= left - 1;
            hold <= slow ? 5 : 2;
        end
        else if (hold > 0)
            hold <= hold - 1;
    end
endmodule : t0cp_pin_model

`default_nettype wire

// ---- tb/tb.sv ----
// tb: self-checking bench for the t0cp timer
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic                clk;
    logic                rst;
    t0cp_pkg::t0cp_cfg_s cfg;
    logic                irq_en;
    logic                sleep;
    t0cp_pkg::t0cp_sw_s  sw;
    logic                pin;
    logic                start;
    logic                slow;
    logic [7:0]          lo;
    logic [7:0]          hi;
    logic                flag;
    logic                irq;
    logic [7:0]          v;
    int                  n_errors = 0;
    int                  checked = 0;
    int                  cycles = 0;

    t0cp_timer dut (
        .clk                 (clk),
        .rst                 (rst),
        .cfg                 (cfg),
        .overflow_irq_enable (irq_en),
        .sleep               (sleep),
        .sw                  (sw),
        .external_count_input(pin),
        .count_low_byte      (lo),
        .count_high_buffer   (hi),
        .overflow_flag       (flag),
        .overflow_irq        (irq)
    );

    t0cp_pin_model m_pin (
        .clk  (clk),
        .start(start),
        .n    (8'h05),
        .slow (slow),
        .pin  (pin)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [16:0] seen,
                       input logic [16:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask : tick

    // kind: 0 write low, 1 write high, 2 read low, 3 clear flag
    task automatic swp(input int kind, input logic [7:0] d);
        @(negedge clk);
        sw = {kind == 0, kind == 1, kind == 2, kind == 3, d};
        @(negedge clk);
        sw = '0;
    endtask : swp

    // bounded: slowest ratio steps every 1024 clocks
    task automatic wait_change;
        logic [7:0] old;
        int         i;
        old = lo;
        for (i = 0; i < 1100 && lo === old; i++)
            @(negedge clk);
    endtask : wait_change

    function automatic int per(input int r);
        return (r == 8) ? t0cp_pkg::CLKS_PER_INSN
                        : t0cp_pkg::CLKS_PER_INSN << (r + 1);
    endfunction : per

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_errors++;
            final_report;
        end
    end

    initial
    begin
        rst = 1'b1;
        cfg = 7'h48;
        irq_en = 1'b0;
        sleep = 1'b0;
        sw = '0;
        start = 1'b0;
        slow = 1'b0;
        void'($urandom(32'h67bf302f));
        tick(3);
        rst = 1'b0;
        // ratios switched on the fly, last pass bypasses
        for (int r = 0; r < 9; r++)
        begin
            cfg.prescaler_assign = (r == 8);
            cfg.prescale_ratio_field = r[2:0];
            wait_change;
            v = lo;
            tick(per(r) - 1);
            chk("steady", lo, v);
            tick(1);
            chk("step", lo, 8'(v + 8'h01));
        end
        $display("test ratios done");
        for (int k = 0; k < 8; k++)
        begin
            cfg.prescaler_assign = (k < 4);
            v = 8'($urandom);
            swp(0, v);
            tick(k < 4 ? 8 : 12);
            chk("stall", lo, v);
            tick(4);
            chk("resume", lo, 8'(v + 8'h01));
        end
        $display("test write stall done");
        cfg.prescaler_assign = 1'b1;
        for (int e = 0; e < 2; e++)
        begin
            irq_en = e[0];
            // park the count far from a wrap so the clear cannot race one
            swp(0, 8'h00);
            swp(3, 8'h00);
            chk("clear", flag, 1'b0);
            swp(0, 8'hff);
            wait_change;
            chk("wrap", {flag, lo}, 9'h100);
            tick(1);
            chk("irq", irq, e[0]);
        end
        $display("test overflow done");
        cfg.width_select = 1'b0;
        swp(3, 8'h00);
        swp(1, 8'h12);
        swp(0, 8'hff);
        // overwrite buffer so the latch has to come from the count
        swp(1, 8'h5a);
        swp(2, 8'h00);
        chk("latch", hi, 8'h12);
        wait_change;
        swp(2, 8'h00);
        chk("carry", {flag, hi, lo}, 17'h01300);
        swp(1, 8'hff);
        swp(0, 8'hff);
        wait_change;
        swp(2, 8'h00);
        chk("word wrap", {flag, hi, lo}, 17'h10000);
        $display("test wide done");
        sleep = 1'b1;
        v = lo;
        tick(40);
        chk("sleep", lo, v);
        sleep = 1'b0;
        $display("test sleep done");
        cfg.count_source_select = 1'b1;
        for (int e = 0; e < 2; e++)
        begin
            cfg.count_edge_select = e[0];
            cfg.width_select = ~e[0];
            slow = e[0];
            swp(0, 8'h00);
            tick(12);
            start = 1'b1;
            tick(1);
            start = 1'b0;
            @(posedge pin);
            tick(5);
            chk("edge", lo, {7'h00, ~e[0]});
            tick(70);
            chk("pulses", lo, 8'h05);
        end
        $display("test counter done");
        final_report;
    end
endmodule : tb

`default_nettype wire

// ---- verilog/t0cp_timer.sv ----
// t0cp_timer: 8/16-bit timer/counter with prescaler and overflow flag
//
// What this block does
// - source bit clear counts instruction cycles
// - low-byte write stalls count two instruction cycles
// - source bit set counts external pin edges
// - edge bit clear rising, set falling
// - pin edges synchronised before counting
// - hidden 8-bit prescale counter
// - assign bit clear: ratio 1:2 to 1:256
// - prescaler assignment changes while running
// - flag set on FFh or FFFFh wrap
// - interrupt only while enable bit set
// - no counting during sleep
// - low read latches high byte to buffer in 16-bit mode
// - low write loads high from buffer in 16-bit mode
`timescale 1ns/1ps
`default_nettype none

module t0cp_timer #(
    parameter int unsigned CLKS_PER_INSN = t0cp_pkg::CLKS_PER_INSN
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // configuration and control
    input  wire t0cp_pkg::t0cp_cfg_s cfg,
    input  wire logic                overflow_irq_enable,
    input  wire logic                sleep,
    // software access
    input  wire t0cp_pkg::t0cp_sw_s  sw,
    // external count pin
    input  wire logic                external_count_input,
    // state seen by software
    output logic [7:0]               count_low_byte,
    output logic [7:0]               count_high_buffer,
    output logic                     overflow_flag,
    output logic                     overflow_irq
);

    localparam int unsigned PW = $clog2(CLKS_PER_INSN);

    generate
        if (CLKS_PER_INSN < 2)
        begin : g_bad_rate
            $error("CLKS_PER_INSN must be at least 2");
        end
    endgenerate

    function automatic logic [7:0] prescale_mask(input logic [2:0] r);
        prescale_mask = 8'hff >> (3'h7 - r);
    endfunction : prescale_mask

    ////////////////////////////////////////////////////////////////////
    // instruction cycle divider

    logic [PW-1:0] phase;
    logic [PW-1:0] next_phase;
    logic          insn_tick;

    always_comb
    begin
        insn_tick  = (phase == PW'(CLKS_PER_INSN - 1));
        next_phase = insn_tick ? '0 : phase + PW'(1);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            phase <= '0;
        else
            phase <= next_phase;
    end

    ////////////////////////////////////////////////////////////////////
    // pin synchroniser; sync1 feeds only sync2

    logic sync1;
    logic sync2;
    logic sync3;
    logic edge_hit;

    always_comb
    begin
        if (cfg.count_edge_select)
            edge_hit = ~sync2 & sync3;
        else
            edge_hit = sync2 & ~sync3;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end
        else
        begin
            sync1 <= external_count_input;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // source select, write inhibit and prescaler

    logic       source_tick;
    logic [1:0] inhibit;
    logic [1:0] next_inhibit;
    logic [7:0] prescale;
    logic [7:0] next_prescale;
    logic [7:0] mask;
    logic       pre_hit;
    logic       adv;

    always_comb
    begin
        // timer is shut off in sleep, so no wake by overflow
        if (sleep)
            source_tick = 1'b0;
        else if (cfg.count_source_select)
            source_tick = edge_hit;
        else
            source_tick = insn_tick;

        next_inhibit = inhibit;
        if (sw.wr_low)
            next_inhibit = t0cp_pkg::INHIBIT_INSN;
        else if (insn_tick && inhibit != 2'h0)
            next_inhibit = inhibit - 2'h1;

        mask    = prescale_mask(cfg.prescale_ratio_field);
        pre_hit = ((prescale & mask) == mask);

        // assignment read live each cycle: switchable while running
        next_prescale = prescale;
        if (sw.wr_low && !cfg.prescaler_assign)
            next_prescale = t0cp_pkg::PRESCALE_ZERO;
        else if (!cfg.prescaler_assign && source_tick)
            next_prescale = prescale + 8'h01;

        if (cfg.prescaler_assign)
            adv = source_tick;
        else
            adv = source_tick && pre_hit;
        adv = adv && (inhibit == 2'h0) && !sw.wr_low;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            inhibit  <= 2'h0;
            prescale <= t0cp_pkg::PRESCALE_ZERO;
        end
        else
        begin
            inhibit  <= next_inhibit;
            prescale <= next_prescale;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // count, high buffer and overflow

    logic [15:0] count;
    logic [15:0] next_count;
    logic [7:0]  buffer;
    logic [7:0]  next_buffer;
    logic        wrap;
    logic        next_flag;
    logic        next_irq;

    always_comb
    begin
        next_count = count;
        wrap       = 1'b0;
        if (sw.wr_low)
        begin
            next_count[7:0] = sw.data;
            if (!cfg.width_select)
                next_count[15:8] = buffer;
        end
        else if (adv && cfg.width_select)
        begin
            next_count[7:0] = count[7:0] + 8'h01;
            wrap = (count[7:0] == t0cp_pkg::LOW_TOP);
        end
        else if (adv)
        begin
            next_count = count + 16'h0001;
            wrap = (count == t0cp_pkg::WORD_TOP);
        end

        next_buffer = buffer;
        if (sw.wr_high)
            next_buffer = sw.data;
        else if (sw.rd_low && !cfg.width_select)
            next_buffer = count[15:8];

        // a wrap in the clearing cycle keeps the flag set
        next_flag = wrap || (overflow_flag && !sw.flag_clear);
        next_irq  = next_flag && overflow_irq_enable;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count         <= t0cp_pkg::COUNT_RESET;
            buffer        <= t0cp_pkg::BUFFER_RESET;
            overflow_flag <= 1'b0;
            overflow_irq  <= 1'b0;
        end
        else
        begin
            count         <= next_count;
            buffer        <= next_buffer;
            overflow_flag <= next_flag;
            overflow_irq  <= next_irq;
        end
    end

    assign count_low_byte    = count[7:0];
    assign count_high_buffer = buffer;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_timer_rate: assert property (
        !cfg.count_source_select && cfg.prescaler_assign && !sleep
        && cfg.width_select && inhibit == 2'h0 && !sw.wr_low
        && insn_tick
        |=> count[7:0] == $past(count[7:0]) + 8'h01)
        else $error("timer mode missed an instruction tick");

    chk_write_inhibit: assert property (
        sw.wr_low ##1 !sw.wr_low [*2]
        |-> $stable(count))
        else $error("count moved during write inhibit");

    chk_sync_delay: assert property (
        $rose(external_count_input) && !cfg.count_edge_select
        ##2 !cfg.count_edge_select
        |-> edge_hit)
        else $error("rising pin edge not seen two cycles later");

    chk_counter_edge: assert property (
        cfg.count_source_select && cfg.prescaler_assign && !sleep
        && cfg.width_select && edge_hit && inhibit == 2'h0
        && !sw.wr_low
        |=> count[7:0] == $past(count[7:0]) + 8'h01)
        else $error("counter mode missed a pin edge");

    chk_prescale_clear: assert property (
        sw.wr_low && !cfg.prescaler_assign
        |=> prescale == t0cp_pkg::PRESCALE_ZERO)
        else $error("prescaler not cleared by low write");

    chk_ratio_step: assert property (
        !cfg.prescaler_assign && adv
        |-> (prescale & prescale_mask(cfg.prescale_ratio_field))
            == prescale_mask(cfg.prescale_ratio_field)
            ##1 (prescale & $past(mask)) == 8'h00)
        else $error("timer advanced before prescale ratio reached");

    chk_overflow_set: assert property (
        adv && cfg.width_select
        && count[7:0] == t0cp_pkg::LOW_TOP
        |=> overflow_flag && count[7:0] == 8'h00)
        else $error("8-bit wrap did not set flag");

    chk_irq_mask: assert property (
        overflow_irq |-> overflow_flag && $past(overflow_irq_enable))
        else $error("interrupt raised while masked");

    chk_sleep_hold: assert property (
        sleep && !sw.wr_low |=> $stable(count))
        else $error("count moved in sleep");

    chk_high_latch: assert property (
        sw.rd_low && !cfg.width_select && !sw.wr_high
        |=> buffer == $past(count[15:8]))
        else $error("low read did not latch high byte");

    chk_full_load: assert property (
        sw.wr_low && !cfg.width_select
        |=> count == {$past(buffer), $past(sw.data)})
        else $error("16-bit load not coherent");

    chk_low_only: assert property (
        cfg.width_select && !sw.wr_low |=> $stable(count[15:8]))
        else $error("high byte moved in 8-bit mode");

    cov_wrap16: cover property (
        adv && !cfg.width_select && count == t0cp_pkg::WORD_TOP);

    cov_flag_race: cover property (wrap && sw.flag_clear);

    cov_ext_prescaled: cover property (
        cfg.count_source_select && !cfg.prescaler_assign && adv);

    cov_assign_switch: cover property (
        $changed(cfg.prescaler_assign) && !sleep);

endmodule : t0cp_timer

`default_nettype wire
